// *** ptw_target.sv ***
// Target end: takes a 32-bit PCI memory write burst and passes it to a back-end.
// Assumes the bus master and back-end share ref_clk; bus pins are synchronous.
// Function
// - Master drives frame, address, command first clock.
// - Master drives byte enables, irdy, first word.
// - Target decodes, shows address to back-end second clock.
// - Region hit goes to back-end third clock.
// - Slow select: devsel one clock after hit.
// - Back-end ready means data accepted two cycles later.
// - Target asserts trdy after sampling back-end ready.
// - Trdy follows ready; words shown one cycle later.
// - Master drives next enables and word after transfer.
// - Strobe marks each word that reached the back-end.
// - Back-end stores word and advances on strobe.
// - Master raises frame during the last word.
// - Master releases lines and drives irdy high at turnaround; irdy released on the idle clock.
// - Target raises devsel and trdy after final transfer.
// - Idle clock clears region hit and strobe.
// - Idle clock releases devsel and trdy.
// - Sequence holds for slow select, no wait states.
`timescale 1ns/1ns
`default_nettype none
module ptw_target
  import ptw_pkg::*;
#(
  parameter ptw_speed_e select_response_speed = SPEED_SLOW
)
(
  // Clock and reset
  input  wire logic                 ref_clk,
  input  wire logic                 rst_n,
  // PCI bus
  ptw_pci_if.device                 pci,
  // Back-end address and selects
  output logic      [DATA_W-1:0]    local_target_addr_out,
  output logic      [BE_W-1:0]      local_cmd_out,
  output logic      [BAR_COUNT-1:0] region_hit,
  // Back-end write data
  input  wire logic                 backend_ready_low,
  output logic      [DATA_W-1:0]    local_wr_data,
  output logic      [BE_W-1:0]      local_wr_be_low,
  output logic                      local_xfer_strobe_low
);
  import ptw_pkg::*;

  ptw_tgt_state_e    state_q, state_d;
  logic [DATA_W-1:0] addr_q;
  logic [BE_W-1:0]   cmd_q;
  logic [BAR_COUNT-1:0] hit_q;
  logic              devsel_q, devsel_oe_q;
  logic              trdy_q, trdy_d, trdy_oe_q;
  logic [DATA_W-1:0] data_q;
  logic [BE_W-1:0]   be_q;
  logic              strobe_q;

  // Decode of bus activity
  wire                 addr_phase = (state_q == TS_IDLE) & ~pci.framen & pci.irdyn;
  wire [BAR_COUNT-1:0] addr_hit   = bar_match(addr_q);
  wire                 cmd_write  = (cmd_q == CMD_MEM_WRITE) | (cmd_q == CMD_MEM_WRITE_INV);
  wire                 claim      = (|addr_hit) & cmd_write;
  // Medium and fast speeds both claim together with the region hit
  wire                 fast_sel   = (select_response_speed != SPEED_SLOW);
  // A word moves on an edge that sees both ready lines low
  wire                 word_taken = (state_q == TS_DATA) & ~pci.irdyn & ~trdy_q;
  wire                 last_taken = word_taken & pci.framen;
  wire                 bus_idle   = pci.framen & pci.irdyn;
  wire                 claim_now  = ((state_q == TS_HIT) & ~fast_sel)
                                    | ((state_q == TS_DECODE) & claim & fast_sel);
  wire                 hit_load   = (state_q == TS_DECODE) & claim;
  wire                 turn_now   = (state_q == TS_TURN);

  always_comb
  begin
    state_d = state_q;
    case (state_q)
      TS_IDLE:   if (addr_phase) state_d = TS_DECODE;
      TS_DECODE: state_d = claim ? TS_HIT : TS_SKIP;
      TS_HIT:    state_d = TS_DATA;
      TS_DATA:   if (last_taken) state_d = TS_TURN;
      TS_TURN:   state_d = TS_IDLE;
      // A miss waits for an idle bus before looking for the next address
      TS_SKIP:   if (bus_idle) state_d = TS_IDLE;
      default:   state_d = TS_IDLE;
    endcase
  end

  // Trdy copies back-end ready while the data phase lasts
  // Outside the data state it is high, which closes the last word
  always_comb
  begin
    trdy_d = 1'b1;
    if (state_d == TS_DATA)
      trdy_d = backend_ready_low;
  end

  // State register
  always_ff @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
      state_q <= TS_IDLE;
    else
      state_q <= state_d;
  end

  // Address and command, captured only from idle so a burst in flight keeps its own
  always_ff @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      addr_q <= '0;
      cmd_q  <= '0;
    end
    else if (addr_phase)
    begin
      addr_q <= pci.ad;
      cmd_q  <= pci.cben;
    end
  end

  // Region hits: set after decode, cleared when the bus goes idle
  // Kept through the turnaround so the back-end can select on them for the last word
  always_ff @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
      hit_q <= '0;
    else if (hit_load)
      hit_q <= addr_hit;
    else if (turn_now)
      hit_q <= '0;
  end

  // Device select: slow select claims one clock after the region hit
  always_ff @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      devsel_q    <= 1'b1;
      devsel_oe_q <= 1'b0;
    end
    else if (claim_now)
    begin
      devsel_q    <= 1'b0;
      devsel_oe_q <= 1'b1;
    end
    else if (last_taken)
      devsel_q <= 1'b1;
    else if (turn_now)
      devsel_oe_q <= 1'b0;
  end

  // Target ready: high for one clock after the last word, then released
  // Enable follows devsel so both lines are driven and released together
  always_ff @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      trdy_q    <= 1'b1;
      trdy_oe_q <= 1'b0;
    end
    else
    begin
      trdy_q <= trdy_d;
      if (claim_now)
        trdy_oe_q <= 1'b1;
      else if (turn_now)
        trdy_oe_q <= 1'b0;
    end
  end

  // Back-end write data, one cycle after the bus transfer
  always_ff @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      data_q <= '0;
      be_q   <= CBE_FLOAT;
    end
    else if (word_taken)
    begin
      data_q <= pci.ad;
      be_q   <= pci.cben;
    end
  end

  // One low strobe cycle for each word accepted on the bus
  always_ff @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
      strobe_q <= 1'b1;
    else
      strobe_q <= ~word_taken;
  end

  // Outputs, all from flip-flops
  assign local_target_addr_out = addr_q;
  assign local_cmd_out         = cmd_q;
  assign region_hit            = hit_q;
  assign local_wr_data         = data_q;
  assign local_wr_be_low       = be_q;
  assign local_xfer_strobe_low = strobe_q;

  // Bus drivers
  assign pci.devseln_o         = devsel_q;
  assign pci.devseln_oe        = devsel_oe_q;
  assign pci.trdyn_o           = trdy_q;
  assign pci.trdyn_oe          = trdy_oe_q;

endmodule
`default_nettype wire

// *** ptw_pkg.sv ***
// Shared constants, types and the address decoder for the PCI burst write pair.
// Assumes both ends and the back-end run on the single PCI clock ref_clk.
`default_nettype none
package ptw_pkg;

  // Bus widths
  localparam int unsigned DATA_W = 32;
  localparam int unsigned BE_W   = 4;
  localparam int unsigned LEN_W  = 8;

  // Bus commands that this target claims
  localparam logic [3:0] CMD_MEM_WRITE     = 4'h7;
  localparam logic [3:0] CMD_MEM_WRITE_INV = 4'hF;

  // Levels seen on a wire that nobody drives (pull-ups on control)
  localparam logic              PIN_PULLUP = 1'b1;
  localparam logic [DATA_W-1:0] AD_FLOAT   = 32'h0000_0000;
  localparam logic [BE_W-1:0]   CBE_FLOAT  = 4'hF;

  // Base address regions
  localparam int unsigned BAR_COUNT = 2;
  localparam logic [DATA_W-1:0] BAR_BASE [BAR_COUNT] = '{32'h1000_0000, 32'h2000_0000};
  localparam logic [DATA_W-1:0] BAR_MASK [BAR_COUNT] = '{32'hFFFF_F000, 32'hFFFF_0000};

  // Timing: master gives up when no target selects within this time
  localparam int unsigned CLK_PERIOD_NS = 8;
  localparam int unsigned ABORT_NS      = 40;
  localparam logic [3:0]  ABORT_CYCLES  = 4'(ABORT_NS / CLK_PERIOD_NS);

  // Device-select response speed
  typedef enum logic [1:0] {
    SPEED_FAST   = 2'b00,
    SPEED_MEDIUM = 2'b01,
    SPEED_SLOW   = 2'b10
  } ptw_speed_e;

  // Target states
  typedef enum logic [2:0] {
    TS_IDLE   = 3'b000,
    TS_DECODE = 3'b001,
    TS_HIT    = 3'b010,
    TS_DATA   = 3'b011,
    TS_TURN   = 3'b100,
    TS_SKIP   = 3'b101
  } ptw_tgt_state_e;

  // Master states
  typedef enum logic [1:0] {
    MS_IDLE = 2'b00,
    MS_ADDR = 2'b01,
    MS_DATA = 2'b10,
    MS_TURN = 2'b11
  } ptw_mst_state_e;

  // One bit per region that holds the address
  function automatic logic [BAR_COUNT-1:0] bar_match(input logic [DATA_W-1:0] addr);
    logic [BAR_COUNT-1:0] hit;
    hit = '0;
    for (int i = 0; i < BAR_COUNT; i++)
    begin
      hit[i] = ((addr & BAR_MASK[i]) == BAR_BASE[i]);
    end
    return hit;
  endfunction

endpackage
`default_nettype wire

// *** ptw_pci_if.sv ***
// PCI bus wires between the burst write master and the target.
// Each driver gives value and enable; undriven wires take pull-up or float level.
`timescale 1ns/1ns
`default_nettype none
interface ptw_pci_if;
  import ptw_pkg::*;

  // Driver sides
  logic [DATA_W-1:0] ad_o;
  logic              ad_oe;
  logic [BE_W-1:0]   cben_o;
  logic              cben_oe;
  logic              framen_o;
  logic              framen_oe;
  logic              irdyn_o;
  logic              irdyn_oe;
  logic              devseln_o;
  logic              devseln_oe;
  logic              trdyn_o;
  logic              trdyn_oe;

  // Resolved wire levels
  logic [DATA_W-1:0] ad;
  logic [BE_W-1:0]   cben;
  logic              framen;
  logic              irdyn;
  logic              devseln;
  logic              trdyn;

  assign ad      = ad_oe      ? ad_o      : AD_FLOAT;
  assign cben    = cben_oe    ? cben_o    : CBE_FLOAT;
  assign framen  = framen_oe  ? framen_o  : PIN_PULLUP;
  assign irdyn   = irdyn_oe   ? irdyn_o   : PIN_PULLUP;
  assign devseln = devseln_oe ? devseln_o : PIN_PULLUP;
  assign trdyn   = trdyn_oe   ? trdyn_o   : PIN_PULLUP;

  modport device (
    input  ad, cben, framen, irdyn,
    output devseln_o, devseln_oe, trdyn_o, trdyn_oe
  );

  modport master (
    input  devseln, trdyn,
    output ad_o, ad_oe, cben_o, cben_oe, framen_o, framen_oe, irdyn_o, irdyn_oe
  );
endinterface
`default_nettype wire

// *** ptw_master.sv ***
// Bus master end: issues one memory write burst per command.
// Assumes the user presents wr_data for data_idx in the same cycle.
`timescale 1ns/1ns
`default_nettype none
module ptw_master
  import ptw_pkg::*;
(
  // Clock and reset
  input  wire logic              ref_clk,
  input  wire logic              rst_n,
  // PCI bus
  ptw_pci_if.master              pci,
  // User command
  input  wire logic              cmd_start,
  input  wire logic [DATA_W-1:0] cmd_addr,
  input  wire logic [LEN_W-1:0]  cmd_len,
  input  wire logic [BE_W-1:0]   cmd_be,
  // User data
  input  wire logic [DATA_W-1:0] wr_data,
  output logic      [LEN_W-1:0]  data_idx,
  // Status
  output logic                   busy,
  output logic                   done,
  output logic                   aborted
);
  import ptw_pkg::*;

  ptw_mst_state_e    state_q, state_d;
  logic [DATA_W-1:0] ad_q;
  logic              ad_oe_q, cben_oe_q, frame_q, frame_oe_q, irdy_q, irdy_oe_q;
  logic [BE_W-1:0]   cben_q, be_q;
  logic [LEN_W-1:0]  left_q, idx_q;
  logic [3:0]        wait_q;
  logic              sel_seen_q, done_q, abort_q;

  wire bus_idle   = pci.trdyn & pci.devseln;
  wire go         = (state_q == MS_IDLE) & cmd_start & (cmd_len != '0) & bus_idle;
  wire taken      = (state_q == MS_DATA) & ~irdy_q & ~pci.trdyn;
  wire last_taken = taken & (left_q == LEN_W'(1));
  wire give_up    = (state_q == MS_DATA) & ~sel_seen_q & pci.devseln
                    & (wait_q == ABORT_CYCLES);

  always_comb
  begin
    state_d = state_q;
    case (state_q)
      MS_IDLE: if (go) state_d = MS_ADDR;
      MS_ADDR: state_d = MS_DATA;
      MS_DATA: if (last_taken | (give_up & frame_q)) state_d = MS_TURN;
      MS_TURN: state_d = MS_IDLE;
      default: state_d = MS_IDLE;
    endcase
  end

  always_ff @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      state_q    <= MS_IDLE;
      ad_q       <= '0;
      ad_oe_q    <= 1'b0;
      cben_q     <= CBE_FLOAT;
      cben_oe_q  <= 1'b0;
      frame_q    <= 1'b1;
      frame_oe_q <= 1'b0;
      irdy_q     <= 1'b1;
      irdy_oe_q  <= 1'b0;
      be_q       <= '0;
      left_q     <= '0;
      idx_q      <= '0;
      wait_q     <= '0;
      sel_seen_q <= 1'b0;
      done_q     <= 1'b0;
      abort_q    <= 1'b0;
    end
    else
    begin
      state_q <= state_d;
      done_q  <= 1'b0;
      abort_q <= 1'b0;
      if (go)
      begin
        // Address phase: frame, address and command
        frame_q    <= 1'b0;
        frame_oe_q <= 1'b1;
        ad_q       <= cmd_addr;
        ad_oe_q    <= 1'b1;
        cben_q     <= CMD_MEM_WRITE;
        cben_oe_q  <= 1'b1;
        irdy_oe_q  <= 1'b1;
        be_q       <= cmd_be;
        left_q     <= cmd_len;
        idx_q      <= '0;
        wait_q     <= '0;
        sel_seen_q <= 1'b0;
      end
      else if (state_q == MS_ADDR)
      begin
        // First data phase: byte enables, ready and first word
        cben_q  <= be_q;
        irdy_q  <= 1'b0;
        ad_q    <= wr_data;
        idx_q   <= idx_q + LEN_W'(1);
        frame_q <= (left_q == LEN_W'(1));
      end
      else if (state_q == MS_DATA)
      begin
        if (~pci.devseln)
          sel_seen_q <= 1'b1;
        if (wait_q != ABORT_CYCLES)
          wait_q <= wait_q + 4'h1;
        if (last_taken | (give_up & frame_q))
        begin
          // Turnaround: release frame, ad, cben; irdy driven high
          frame_oe_q <= 1'b0;
          ad_oe_q    <= 1'b0;
          cben_oe_q  <= 1'b0;
          irdy_q     <= 1'b1;
          abort_q    <= ~last_taken;
        end
        else if (give_up)
          frame_q <= 1'b1;
        else if (taken)
        begin
          // Next word after an accepted one
          cben_q  <= be_q;
          ad_q    <= wr_data;
          idx_q   <= idx_q + LEN_W'(1);
          left_q  <= left_q - LEN_W'(1);
          frame_q <= (left_q == LEN_W'(2));
        end
      end
      else if (state_q == MS_TURN)
      begin
        irdy_oe_q <= 1'b0;
        done_q    <= 1'b1;
      end
    end
  end

  assign pci.ad_o      = ad_q;
  assign pci.ad_oe     = ad_oe_q;
  assign pci.cben_o    = cben_q;
  assign pci.cben_oe   = cben_oe_q;
  assign pci.framen_o  = frame_q;
  assign pci.framen_oe = frame_oe_q;
  assign pci.irdyn_o   = irdy_q;
  assign pci.irdyn_oe  = irdy_oe_q;
  assign data_idx      = idx_q;
  assign busy          = irdy_oe_q; // Irdy enable spans the whole burst, frame included
  assign done          = done_q;
  assign aborted       = abort_q;

endmodule
`default_nettype wire

// *** ptw_props.sv ***
// Bus-side properties of the burst write pair.
// Assumes one clock and the resolved wires of the bus interface.
`timescale 1ns/1ns
`default_nettype none
module ptw_props (
  // Clock and reset
  input wire logic        ref_clk,
  input wire logic        rst_n,
  // Resolved wires
  input wire logic [31:0] ad,
  input wire logic [3:0]  cben,
  input wire logic        framen,
  input wire logic        irdyn,
  input wire logic        devseln,
  input wire logic        trdyn,
  // Driver enables
  input wire logic        ad_oe,
  input wire logic        cben_oe,
  input wire logic        framen_oe,
  input wire logic        irdyn_oe,
  input wire logic        devseln_oe,
  input wire logic        trdyn_oe
);
  wire logic in_bar = (ad[31:12] == 20'h10000) || (ad[31:16] == 16'h2000);
  wire logic claim  = in_bar && (cben == 4'h7 || cben == 4'hF);
  wire logic last_x = !irdyn && !trdyn && framen;

  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rst_n);

  property p_addr_phase;
    $fell(framen) |-> ad_oe && cben_oe && irdyn ##1 !irdyn;
  endproperty
  a_addr_phase: assert property (p_addr_phase)
    else $error("address phase malformed");

  property p_select_slow;
    $fell(framen) && claim |-> ##1 devseln ##1 devseln ##1 !devseln;
  endproperty
  a_select_slow: assert property (p_select_slow)
    else $error("select not in fourth clock");

  property p_miss_quiet;
    $fell(framen) && !claim |-> !devseln_oe [*8];
  endproperty
  a_miss_quiet: assert property (p_miss_quiet)
    else $error("target drove select on a miss");

  property p_trdy_in_select;
    !trdyn |-> !devseln && !irdyn;
  endproperty
  a_trdy_in_select: assert property (p_trdy_in_select)
    else $error("target ready outside a selected data phase");

  property p_wait_hold;
    !irdyn && trdyn && !devseln |=> $stable(ad) && $stable(cben);
  endproperty
  a_wait_hold: assert property (p_wait_hold)
    else $error("data moved without a transfer");

  property p_last_mark;
    $rose(framen) |-> !irdyn;
  endproperty
  a_last_mark: assert property (p_last_mark)
    else $error("frame raised outside the last data phase");

  property p_master_turn;
    last_x |=> irdyn && irdyn_oe && !framen_oe && !ad_oe && !cben_oe ##1 !irdyn_oe;
  endproperty
  a_master_turn: assert property (p_master_turn)
    else $error("master turnaround wrong");

  property p_target_turn;
    last_x |=> devseln && trdyn && devseln_oe && trdyn_oe ##1 !devseln_oe && !trdyn_oe;
  endproperty
  a_target_turn: assert property (p_target_turn)
    else $error("target turnaround wrong");
endmodule
`default_nettype wire

// *** tb_pci_target_burst_write_32.sv ***
// Self-checking bench: master and target joined over the bus interface.
// Assumes the package regions; the back-end is modelled here.
`timescale 1ns/1ns
`default_nettype none
module tb_pci_target_burst_write_32;
  import ptw_pkg::*;
  logic        ref_clk = 1'b0;
  logic        rst_n = 1'b0;
  logic        cmd_start = 1'b0;
  logic [31:0] cmd_addr = '0;
  logic [7:0]  cmd_len = 8'h01;
  logic [3:0]  cmd_be = 4'h0;
  logic [31:0] wr_data;
  logic [7:0]  data_idx;
  logic        busy, done, aborted;
  logic [31:0] local_target_addr_out, local_wr_data;
  logic [3:0]  local_cmd_out, local_wr_be_low;
  logic [1:0]  region_hit, exp_hit;
  logic        backend_ready_low = 1'b1;
  logic        local_xfer_strobe_low;
  logic [31:0] words [256];
  logic [31:0] exp_q [$];
  logic        rdy_rand = 1'b0, r1 = 1'b1, r2 = 1'b1, seen_abort = 1'b0;
  int          failures = 0, samples_checked = 0, cyc = 0, first_s, last_s;

  always #4 ref_clk = ~ref_clk;
  assign wr_data = words[data_idx];

  ptw_pci_if pci ();
  ptw_master i_ptw_master (.ref_clk, .rst_n, .pci(pci), .cmd_start, .cmd_addr, .cmd_len,
    .cmd_be, .wr_data, .data_idx, .busy, .done, .aborted);
  ptw_target #(.select_response_speed(SPEED_SLOW)) i_ptw_target (.ref_clk, .rst_n, .pci(pci),
    .local_target_addr_out, .local_cmd_out, .region_hit, .backend_ready_low, .local_wr_data,
    .local_wr_be_low, .local_xfer_strobe_low);
  ptw_props i_ptw_props (.ref_clk, .rst_n, .ad(pci.ad), .cben(pci.cben), .framen(pci.framen),
    .irdyn(pci.irdyn), .devseln(pci.devseln), .trdyn(pci.trdyn), .ad_oe(pci.ad_oe),
    .cben_oe(pci.cben_oe), .framen_oe(pci.framen_oe), .irdyn_oe(pci.irdyn_oe),
    .devseln_oe(pci.devseln_oe), .trdyn_oe(pci.trdyn_oe));

  task automatic chk_word(input string what, input logic [31:0] exp, input logic [31:0] got);
    samples_checked++;
    if (got !== exp)
    begin
      failures++;
      $display("unexpected %s: expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic chk_flag(input string what, input logic exp, input logic got);
    samples_checked++;
    if (got !== exp)
    begin
      failures++;
      $display("unexpected %s: expected %b seen %b", what, exp, got);
    end
  endtask

  task automatic final_report();
    $display("comparisons %0d mismatches %0d", samples_checked, failures);
    if (failures == 0 && samples_checked > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask

  // Back-end ready and its two-cycle history
  always @(posedge ref_clk)
  begin
    cyc <= cyc + 1;
    r1 <= backend_ready_low;
    r2 <= r1;
    backend_ready_low <= rdy_rand ? ($urandom_range(3) == 0) : 1'b0;
  end

  // Back-end model: every strobe takes the next expected word
  always @(negedge ref_clk)
  begin
    if (rst_n)
    begin
      if (aborted === 1'b1)
        seen_abort = 1'b1;
      if (r1 === 1'b1 && pci.trdyn_oe === 1'b1)
        chk_flag("trdyn after ready high", 1'b1, pci.trdyn);
      if (local_xfer_strobe_low === 1'b0)
      begin
        if (exp_q.size() == 0)
          chk_flag("spare strobe", 1'b1, 1'b0);
        else
          chk_word("write data", exp_q.pop_front(), local_wr_data);
        chk_word("byte enables", {28'h0, cmd_be}, {28'h0, local_wr_be_low});
        chk_word("target address", cmd_addr, local_target_addr_out);
        chk_word("command", {28'h0, CMD_MEM_WRITE}, {28'h0, local_cmd_out});
        chk_word("region hit", {30'h0, exp_hit}, {30'h0, region_hit});
        chk_flag("ready two cycles back", 1'b0, r2);
        if (first_s < 0)
          first_s = cyc;
        last_s = cyc;
      end
    end
  end

  task automatic run(input logic [31:0] addr, input int len, input logic mode);
    int n;
    exp_hit = {addr[31:16] == 16'h2000, addr[31:12] == 20'h10000};
    seen_abort = 1'b0;
    first_s = -1;
    rdy_rand = mode;
    for (int i = 0; i < len; i++)
    begin
      words[i] = $urandom;
      if (exp_hit != 2'b00)
        exp_q.push_back(words[i]);
    end
    @(posedge ref_clk);
    cmd_start <= 1'b1;
    cmd_addr <= addr;
    cmd_len <= len[7:0];
    cmd_be <= 4'($urandom);
    @(posedge ref_clk);
    cmd_start <= 1'b0;
    n = 0;
    while (done !== 1'b1 && n < 3000)
    begin
      @(negedge ref_clk);
      n++;
    end
    chk_flag("done seen", 1'b1, done);
    chk_flag("abort", exp_hit == 2'b00, seen_abort);
    chk_word("words left", 0, exp_q.size());
    chk_word("region hit at end", 0, {30'h0, region_hit});
    chk_flag("strobe at end", 1'b1, local_xfer_strobe_low);
    chk_flag("busy at end", 1'b0, busy);
    if (!mode && exp_hit != 2'b00)
      chk_word("strobe span", len - 1, last_s - first_s);
    exp_q.delete();
    repeat (3) @(posedge ref_clk);
  endtask

  initial
  begin
    logic [31:0] a;
    void'($urandom(85));
    repeat (12) @(posedge ref_clk);
    rst_n <= 1'b1;
    run(32'h1000_0000, 1, 1'b0);
    run(32'h2000_FFF0, 3, 1'b0);
    run(32'h1000_0FFC, 255, 1'b0);
    run(32'h1000_1000, 2, 1'b0);
    run(32'h2001_0000, 2, 1'b1);
    for (int k = 0; k < 10; k++)
    begin
      a = $urandom_range(1) ? (32'h1000_0000 | ($urandom & 32'hFFC))
                            : (32'h2000_0000 | ($urandom & 32'hFFFC));
      run(a, $urandom_range(16, 1), 1'b1);
    end
    final_report();
  end

  // Whole run needs a few hundred cycles; this allows 50000
  initial
  begin
    #400_000;
    failures++;
    final_report();
  end
endmodule
`default_nettype wire
